// File: dv/dfac_antenna_model.sv
`timescale 1ns/1ps
// External switch bank: latches the pins one edge late, so checks sample mid-interval
module dfac_antenna_model (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [7:0] antenna_gpio_in,
	input wire logic active_in,
	output logic [7:0] selected_out,
	output logic [15:0] idle_drive_out
);
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			selected_out <= 8'h00;
			idle_drive_out <= 16'h0000;
		end else begin
			selected_out <= antenna_gpio_in;
			if (!active_in && antenna_gpio_in !== 8'h00) begin
				idle_drive_out <= idle_drive_out + 16'h0001;
			end
		end
	end
endmodule // dfac_antenna_model

// File: dv/dfac_top_test.sv
`timescale 1ns/1ps
`include "dfac_params.svh"
module dfac_top_test;
	logic core_clk_in = 1'h0;
	logic reset_in = 1'h1;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic trig = 1'h0;
	logic tx_mode = 1'h1;
	logic type_1us = 1'h0;
	logic [11:0] adr = 12'h000;
	logic [3:0] sel = 4'hf;
	logic [31:0] wdat = 32'h00000000;
	logic [5:0] parsed = 6'h00;
	logic [31:0] rdat;
	logic ack, strobe, fmt_out, ext_out, active;
	logic [7:0] gpio, selected;
	logic [3:0] lna, mix, aaf;
	logic [15:0] idle_drive;
	logic [31:0] seed = 32'h0000002d;
	logic [31:0] q;
	int mismatches = 0;
	int tests_run = 0;

	dfac_top dut_u (.core_clk_in(core_clk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
		.proc_trigger_in(trig), .tx_mode_in(tx_mode), .parsed_units_in(parsed), .parsed_type_1us_in(type_1us),
		.antenna_gpio_out(gpio), .sample_strobe_out(strobe), .magnitude_phase_format_out(fmt_out),
		.cte_in_extension_out(ext_out), .cte_active_out(active), .low_noise_amp_backoff_out(lna),
		.mixer_backoff_out(mix), .antialias_filter_backoff_out(aaf));
	dfac_antenna_model ant_u (.core_clk_in(core_clk_in), .reset_in(reset_in), .antenna_gpio_in(gpio),
		.active_in(active), .selected_out(selected), .idle_drive_out(idle_drive));

	initial begin
		forever #5 core_clk_in = ~core_clk_in;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic int spc(input int code);
		int t[8] = '{400, 400, 200, 100, 50, 25, 12, 400};
		return t[code];
	endfunction

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			mismatches++;
		end
	endtask

	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [31:0] r);
		int n;
		@(posedge core_clk_in);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		for (n = 0; n < 16; n++) begin
			@(posedge core_clk_in);
			if (ack === 1'h1) break;
		end
		r = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		if (n == 16) begin
			$display("mismatch wb_ack_out expected 1 seen 0");
			mismatches++;
			wrap_up();
		end
	endtask

	task automatic run_proc(input int r);
		logic [31:0] rnd, cfg, rd;
		int units, swc, refc, sspc, gain, swoff, soff, sw0, samp, fin, iv, sp, k, m, act, nq, l, x;
		int st[$];
		logic [7:0] p[3];
		rnd = xs();
		units = 5 + rnd[1:0] % 3;
		swc = (r == 3) ? 1 + rnd[2] : 1 + rnd[3:2] % 3;
		refc = 1 + rnd[6:4] % 6;
		sspc = 1 + rnd[9:7] % 6;
		gain = rnd[13:10] % 13;
		swoff = (r == 1) ? -40 : (r == 2) ? 32 : 0;
		soff = (r == 2) ? -2000 : -8;
		sw0 = (swoff * 100 / 16 > 0) ? swoff * 100 / 16 : 0;
		samp = sw0 + 1200 + soff * 100 / 16;
		samp = (samp < 0) ? 0 : samp;
		// Receive with inline parsing takes the length from the parsed input
		l = (r == 3) ? 2 : units;
		cfg = {4'h0, gain[3:0], 5'h00, sspc[2:0], rnd[14], refc[2:0], 2'h0, swc[1:0], rnd[15], 1'h0, l[5:0]};
		wb(1'h1, `DFAC_ADR_CONFIG, cfg, 4'hf, rd);
		wb(1'h1, `DFAC_ADR_OFFSETS, {4'h0, soff[11:0], 3'h0, swoff[12:0]}, 4'hf, rd);
		wb(1'h1, `DFAC_ADR_INLINE, (r == 3) ? 32'h00000231 : 32'h00000000, 4'hf, rd);
		wb(1'h0, `DFAC_ADR_CONFIG, 32'h00000000, 4'hf, rd);
		chk("config", cfg, rd);
		chk("format", {31'h0, cfg[15]}, {31'h0, fmt_out});
		chk("placement", {31'h0, cfg[7]}, {31'h0, ext_out});
		tx_mode <= (r != 3);
		parsed <= units[5:0];
		wb(1'h1, `DFAC_ADR_CLEAR, xs(), 4'hf, rd);
		wb(1'h0, `DFAC_ADR_STATUS, 32'h00000000, 4'hf, rd);
		chk("cleared count", 32'h00000000, {24'h0, rd[7:0]});
		for (m = 0; m < 3; m++) begin
			rnd = xs();
			p[m] = {rnd[7:2], m[1:0]};
			wb(1'h1, `DFAC_ADR_PUSH, {rnd[31:8], p[m]}, 4'h1, rd);
		end
		wb(1'h0, `DFAC_ADR_STATUS, 32'h00000000, 4'hf, rd);
		chk("pattern count", 32'h00000003, {24'h0, rd[7:0]});
		fin = sw0 + units * 800;
		iv = spc(swc);
		// Arrival mode inline: 2 us switching takes short (code 3), 4 us long (code 2)
		sp = (r == 3) ? ((swc == 2) ? 100 : 200) : spc(sspc);
		x = (gain < 4) ? gain : 4;
		act = 0;
		@(posedge core_clk_in);
		trig <= 1'h1;
		for (k = 0; k < fin + 8; k++) begin
			@(posedge core_clk_in);
			trig <= (k == 50);
			#1;
			if (active === 1'h1) act++;
			if (strobe === 1'h1) st.push_back(k);
			if (k == 0) begin
				chk("lna steps", x, {28'h0, lna});
				chk("mixer steps", (gain - x < 4) ? gain - x : 4, {28'h0, mix});
				chk("filter steps", (gain > 8) ? gain - 8 : 0, {28'h0, aaf});
			end
			if (k == sw0 + 2) chk("reference pattern", {24'h0, p[0]}, {24'h0, selected});
			m = k - sw0 - 2000;
			if (m >= 0 && m < 4 * iv && m % iv == iv / 2) begin
				chk("switch pattern", {24'h0, p[1 + (m / iv) % 2]}, {24'h0, selected});
			end
		end
		nq = st.size();
		chk("active length", fin + 1, act);
		chk("first sample", samp + 1, (nq > 1) ? st[0] : -1);
		chk("reference spacing", spc(refc), (nq > 1) ? st[1] - st[0] : -1);
		chk("switching spacing", sp, (nq > 1) ? st[nq - 1] - st[nq - 2] : -1);
	endtask

	initial begin
		repeat (20) @(posedge core_clk_in);
		reset_in <= 1'h0;
		wb(1'h0, `DFAC_ADR_CONFIG, 32'h00000000, 4'hf, q);
		chk("config reset", 32'h00023282, q);
		chk("placement reset", 32'h00000001, {31'h0, ext_out});
		wb(1'h0, `DFAC_ADR_OFFSETS, 32'h00000000, 4'hf, q);
		chk("offsets reset", 32'h00000000, q);
		wb(1'h1, 12'h9f0, xs(), 4'hf, q);
		wb(1'h0, 12'h9f0, 32'h00000000, 4'hf, q);
		chk("unmapped", 32'h00000000, q);
		wb(1'h0, `DFAC_ADR_CLEAR, 32'h00000000, 4'hf, q);
		chk("clear read", 32'h00000000, q);
		// Only byte 1 may land: bits 15:8 become f3
		wb(1'h1, `DFAC_ADR_CONFIG, 32'hffffffff, 4'h2, q);
		wb(1'h0, `DFAC_ADR_CONFIG, 32'h00000000, 4'hf, q);
		chk("byte merge", 32'h0002f382, q);
		chk("format set", 32'h00000001, {31'h0, fmt_out});
		for (int r = 0; r < 4; r++) begin
			run_proc(r);
		end
		chk("idle drive", 32'h00000000, {16'h0, idle_drive});
		wrap_up();
	end
endmodule // dfac_top_test

// File: src/dfac_gain_split.sv
`timescale 1ns/1ps
module dfac_gain_split #(
	parameter int LNA_MAX = 4,
	parameter int MIX_MAX = 4,
	parameter int AAF_MAX = 4
) (
	input wire logic [3:0] steps_in,
	output logic [3:0] lna_out,
	output logic [3:0] mix_out,
	output logic [3:0] aaf_out
);
	if (LNA_MAX < 0 || MIX_MAX < 0 || AAF_MAX < 0 || LNA_MAX + MIX_MAX + AAF_MAX > 15) begin : g_bad_max
		$error("dfac_gain_split: step limits out of range");
	end

	localparam logic [3:0] LNA_LIM = 4'(LNA_MAX);
	localparam logic [3:0] MIX_LIM = 4'(MIX_MAX);
	localparam logic [3:0] AAF_LIM = 4'(AAF_MAX);

	logic [3:0] rest;

	// Amplifier first, mixer next, filter last; surplus beyond all three is lost
	always_comb begin
		lna_out = (steps_in > LNA_LIM) ? LNA_LIM : steps_in;
		rest = steps_in - lna_out;
		mix_out = (rest > MIX_LIM) ? MIX_LIM : rest;
		rest = rest - mix_out;
		aaf_out = (rest > AAF_LIM) ? AAF_LIM : rest;
	end
endmodule // dfac_gain_split

// File: src/dfac_params.svh
`ifndef DFAC_PARAMS_SVH
`define DFAC_PARAMS_SVH

// Register byte addresses
`define DFAC_ADR_CONFIG 12'h910
`define DFAC_ADR_OFFSETS 12'h914
`define DFAC_ADR_INLINE 12'h918
`define DFAC_ADR_STATUS 12'h91c
`define DFAC_ADR_PUSH 12'h928
`define DFAC_ADR_CLEAR 12'h92c

// Reset values and writable-bit masks
`define DFAC_CONFIG_RESET 32'h00023282
`define DFAC_OFFSETS_RESET 32'h00000000
`define DFAC_INLINE_RESET 32'h00000220
`define DFAC_CONFIG_MASK 32'h0f07f3bf
`define DFAC_OFFSETS_MASK 32'h0fff1fff
`define DFAC_INLINE_MASK 32'h00001771

// direction_finding_config fields
`define DFAC_F_LEN 5:0
`define DFAC_F_PLACE 7
`define DFAC_F_SWSP 9:8
`define DFAC_F_REFSP 14:12
`define DFAC_F_FMT 15
`define DFAC_F_SSP 18:16
`define DFAC_F_GAIN 27:24
// direction_finding_offsets fields
`define DFAC_F_SWOFF 12:0
`define DFAC_F_SAMPOFF 27:16
// Inline control fields
`define DFAC_F_INL_EN 0
`define DFAC_F_INL_SHORT 6:4
`define DFAC_F_INL_LONG 10:8
`define DFAC_F_AOD 12

// Timing
`define DFAC_CLK_MHZ 100
`define DFAC_OFFSET_CLK_MHZ 16
`define DFAC_LEN_UNIT_US 8
`define DFAC_REF_START_US 12
`define DFAC_REF_LEN_US 8
`define DFAC_LEN_UNIT_CYC (`DFAC_LEN_UNIT_US * `DFAC_CLK_MHZ)
`define DFAC_REF_START_CYC (`DFAC_REF_START_US * `DFAC_CLK_MHZ)
`define DFAC_REF_LEN_CYC (`DFAC_REF_LEN_US * `DFAC_CLK_MHZ)
`define DFAC_MIN_PATTERNS 3

`endif

// File: src/dfac_pat_if.sv
`timescale 1ns/1ps
interface dfac_pat_if #(parameter int DEPTH = 16) ();
	localparam int AW = $clog2(DEPTH);
	logic push;
	logic clear;
	dfac_pkg::dfac_pattern_t wdata;
	logic [AW-1:0] rd_idx;
	dfac_pkg::dfac_pattern_t rd_data;
	logic [AW:0] count;
	modport store (input push, input clear, input wdata, input rd_idx, output rd_data, output count);
	modport user (output push, output clear, output wdata, output rd_idx, input rd_data, input count);
endinterface

// File: src/dfac_pattern_store.sv
`timescale 1ns/1ps
`include "dfac_params.svh"
module dfac_pattern_store #(
	parameter int DEPTH = 16
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	dfac_pat_if.store pat
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	if (DEPTH < `DFAC_MIN_PATTERNS || DEPTH > 256) begin : g_bad_depth
		$error("dfac_pattern_store: DEPTH out of range");
	end

	dfac_pkg::dfac_pattern_t mem [DEPTH];
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic do_write;

	// Clear wins over a push in the same cycle; pushes past a full array are dropped
	always_comb begin
		do_write = pat.push && !pat.clear && count < FULL;
		next_count = count;
		if (pat.clear) begin
			next_count = '0;
		end else if (do_write) begin
			next_count = count + (AW+1)'(1);
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (do_write) begin
			mem[count[AW-1:0]] <= pat.wdata;
		end
	end

	assign pat.count = count;
	assign pat.rd_data = mem[pat.rd_idx];
endmodule // dfac_pattern_store

// File: src/dfac_pkg.sv
package dfac_pkg;
	typedef enum logic [1:0] {
		DFAC_IDLE = 2'h0,
		DFAC_DELAY = 2'h1,
		DFAC_REFER = 2'h3,
		DFAC_SWITCH = 2'h2
	} dfac_state_e;
	typedef logic [7:0] dfac_pattern_t;
endpackage

// File: src/dfac_top.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "dfac_params.svh"
module dfac_top #(
	parameter int PATTERN_DEPTH = 16,
	parameter int LNA_MAX_STEPS = 4,
	parameter int MIX_MAX_STEPS = 4,
	parameter int AAF_MAX_STEPS = 4
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [11:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic proc_trigger_in,
	input wire logic tx_mode_in,
	input wire logic [5:0] parsed_units_in,
	input wire logic parsed_type_1us_in,
	output logic [7:0] antenna_gpio_out,
	output logic sample_strobe_out,
	output logic magnitude_phase_format_out,
	output logic cte_in_extension_out,
	output logic cte_active_out,
	output logic [3:0] low_noise_amp_backoff_out,
	output logic [3:0] mixer_backoff_out,
	output logic [3:0] antialias_filter_backoff_out
);
	localparam int CW = 20;
	localparam int AW = $clog2(PATTERN_DEPTH);
	localparam logic signed [CW:0] K_MUL = (CW+1)'(`DFAC_CLK_MHZ);
	localparam logic signed [CW:0] K_DIV = (CW+1)'(`DFAC_OFFSET_CLK_MHZ);

	if (PATTERN_DEPTH < `DFAC_MIN_PATTERNS || PATTERN_DEPTH > 256) begin : g_bad_depth
		$error("dfac_top: PATTERN_DEPTH out of range");
	end

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel, input logic [31:0] mask);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		merge = r & mask;
	endfunction

	// Interval codes shared by antenna switching and both sample spacings
	function automatic logic [CW-1:0] spacing_cycles(input logic [2:0] code);
		case (code)
			3'h2: spacing_cycles = CW'(2 * `DFAC_CLK_MHZ);
			3'h3: spacing_cycles = CW'(`DFAC_CLK_MHZ);
			3'h4: spacing_cycles = CW'(`DFAC_CLK_MHZ / 2);
			3'h5: spacing_cycles = CW'(`DFAC_CLK_MHZ / 4);
			3'h6: spacing_cycles = CW'(`DFAC_CLK_MHZ / 8);
			default: spacing_cycles = CW'(4 * `DFAC_CLK_MHZ);
		endcase
	endfunction

	dfac_pat_if #(.DEPTH(PATTERN_DEPTH)) pat ();

	dfac_pattern_store #(.DEPTH(PATTERN_DEPTH)) u_store (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.pat(pat.store)
	);

	// Register file over classic Wishbone
	logic [31:0] cfg;
	logic [31:0] next_cfg;
	logic [31:0] offs;
	logic [31:0] next_offs;
	logic [31:0] inl;
	logic [31:0] next_inl;
	logic [7:0] last_push;
	logic [7:0] next_last_push;
	logic ack;
	logic next_ack;
	logic [31:0] rdat;
	logic [31:0] next_rdat;
	logic req;
	logic wr;
	dfac_pkg::dfac_state_e state;
	dfac_pkg::dfac_state_e next_state;

	always_comb begin
		req = wb_cyc_in && wb_stb_in && !ack;
		wr = req && wb_we_in;
		next_ack = req;
		next_cfg = cfg;
		next_offs = offs;
		next_inl = inl;
		next_last_push = last_push;
		next_rdat = rdat;
		pat.push = 1'b0;
		pat.clear = 1'b0;
		pat.wdata = wb_dat_in[7:0];
		if (wr) begin
			case (wb_adr_in)
				`DFAC_ADR_CONFIG: next_cfg = merge(cfg, wb_dat_in, wb_sel_in, `DFAC_CONFIG_MASK);
				`DFAC_ADR_OFFSETS: next_offs = merge(offs, wb_dat_in, wb_sel_in, `DFAC_OFFSETS_MASK);
				`DFAC_ADR_INLINE: next_inl = merge(inl, wb_dat_in, wb_sel_in, `DFAC_INLINE_MASK);
				`DFAC_ADR_PUSH: begin
					pat.push = wb_sel_in[0];
					next_last_push = wb_sel_in[0] ? wb_dat_in[7:0] : last_push;
				end
				`DFAC_ADR_CLEAR: pat.clear = 1'b1;
				default: ;
			endcase
		end
		if (req && !wb_we_in) begin
			case (wb_adr_in)
				`DFAC_ADR_CONFIG: next_rdat = cfg;
				`DFAC_ADR_OFFSETS: next_rdat = offs;
				`DFAC_ADR_INLINE: next_rdat = inl;
				`DFAC_ADR_STATUS: next_rdat = {16'h0000, 2'h0, cte_active_out, 1'b0, 2'h0, state,
					8'(pat.count)};
				`DFAC_ADR_PUSH: next_rdat = {24'h000000, last_push};
				default: next_rdat = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cfg <= `DFAC_CONFIG_RESET;
			offs <= `DFAC_OFFSETS_RESET;
			inl <= `DFAC_INLINE_RESET;
			last_push <= 8'h00;
			ack <= 1'b0;
			rdat <= 32'h00000000;
		end else begin
			cfg <= next_cfg;
			offs <= next_offs;
			inl <= next_inl;
			last_push <= next_last_push;
			ack <= next_ack;
			rdat <= next_rdat;
		end
	end

	assign wb_ack_out = ack;
	assign wb_dat_out = rdat;

	// Procedure timing
	logic [CW-1:0] elapsed;
	logic [CW-1:0] next_elapsed;
	logic [5:0] units;
	logic [5:0] next_units;
	logic [AW-1:0] pat_idx;
	logic [AW-1:0] next_pat_idx;
	logic [CW-1:0] sw_cnt;
	logic [CW-1:0] next_sw_cnt;
	logic [CW-1:0] samp_cnt;
	logic [CW-1:0] next_samp_cnt;
	logic signed [CW:0] sw_off_cyc;
	logic signed [CW:0] samp_raw;
	logic [CW-1:0] sw_start;
	logic [CW-1:0] ref_start;
	logic [CW-1:0] swp_start;
	logic [CW-1:0] samp_start;
	logic [CW-1:0] cte_end;
	logic [2:0] switch_samp_code;
	logic [2:0] samp_code;
	logic inline_rx;
	logic sw_tick;
	logic samp_on;
	logic next_strobe;
	logic [7:0] next_gpio;
	logic [3:0] lna_steps;
	logic [3:0] mix_steps;
	logic [3:0] aaf_steps;
	logic [3:0] next_lna;
	logic [3:0] next_mix;
	logic [3:0] next_aaf;

	dfac_gain_split #(.LNA_MAX(LNA_MAX_STEPS), .MIX_MAX(MIX_MAX_STEPS), .AAF_MAX(AAF_MAX_STEPS)) u_gain (
		.steps_in(cfg[`DFAC_F_GAIN]),
		.lna_out(lna_steps),
		.mix_out(mix_steps),
		.aaf_out(aaf_steps)
	);

	always_comb begin
		// Offsets arrive in 16 MHz cycles; rescaled to core cycles and clamped at the trigger
		sw_off_cyc = ($signed({{(CW-12){offs[12]}}, offs[`DFAC_F_SWOFF]}) * K_MUL) / K_DIV;
		sw_start = sw_off_cyc < 0 ? '0 : sw_off_cyc[CW-1:0];
		ref_start = sw_start + CW'(`DFAC_REF_START_CYC);
		swp_start = ref_start + CW'(`DFAC_REF_LEN_CYC);
		samp_raw = $signed({1'b0, ref_start}) +
			($signed({{(CW-11){offs[27]}}, offs[`DFAC_F_SAMPOFF]}) * K_MUL) / K_DIV;
		samp_start = samp_raw < 0 ? '0 : samp_raw[CW-1:0];
		cte_end = sw_start + CW'(units) * CW'(`DFAC_LEN_UNIT_CYC);
		inline_rx = inl[`DFAC_F_INL_EN] && !tx_mode_in;
		// Inline parsing replaces the switching-period sample spacing field in receive
		if (!inline_rx) begin
			switch_samp_code = cfg[`DFAC_F_SSP];
		end else if (inl[`DFAC_F_AOD]) begin
			switch_samp_code = parsed_type_1us_in ? inl[`DFAC_F_INL_SHORT] : inl[`DFAC_F_INL_LONG];
		end else begin
			switch_samp_code = cfg[`DFAC_F_SWSP] == 2'h2 ? inl[`DFAC_F_INL_SHORT] : inl[`DFAC_F_INL_LONG];
		end
		samp_code = state == dfac_pkg::DFAC_SWITCH ? switch_samp_code : cfg[`DFAC_F_REFSP];
	end

	always_comb begin
		next_state = state;
		next_elapsed = state == dfac_pkg::DFAC_IDLE ? '0 : elapsed + CW'(1);
		next_units = units;
		next_pat_idx = pat_idx;
		next_sw_cnt = sw_cnt;
		sw_tick = 1'b0;
		next_lna = low_noise_amp_backoff_out;
		next_mix = mixer_backoff_out;
		next_aaf = antialias_filter_backoff_out;
		unique case (state)
			dfac_pkg::DFAC_IDLE: begin
				if (proc_trigger_in) begin
					next_state = dfac_pkg::DFAC_DELAY;
					next_units = (tx_mode_in || !inl[`DFAC_F_INL_EN]) ? cfg[`DFAC_F_LEN] : parsed_units_in;
					next_pat_idx = '0;
					next_lna = lna_steps;
					next_mix = mix_steps;
					next_aaf = aaf_steps;
				end
			end
			dfac_pkg::DFAC_DELAY: begin
				if (elapsed >= sw_start) begin
					next_state = dfac_pkg::DFAC_REFER;
				end
			end
			dfac_pkg::DFAC_REFER: begin
				if (elapsed >= swp_start) begin
					next_state = dfac_pkg::DFAC_SWITCH;
					sw_tick = 1'b1;
				end
			end
			dfac_pkg::DFAC_SWITCH: begin
				sw_tick = sw_cnt == '0;
				next_sw_cnt = sw_cnt - CW'(1);
			end
		endcase
		if (sw_tick) begin
			next_sw_cnt = spacing_cycles({1'b0, cfg[`DFAC_F_SWSP]}) - CW'(1);
			if (pat.count > (AW+1)'(pat_idx) + (AW+1)'(1)) begin
				next_pat_idx = pat_idx + AW'(1);
			end else if (pat.count > (AW+1)'(1)) begin
				next_pat_idx = AW'(1);
			end
		end
		if (state != dfac_pkg::DFAC_IDLE && elapsed >= cte_end) begin
			next_state = dfac_pkg::DFAC_IDLE;
			next_lna = 4'h0;
			next_mix = 4'h0;
			next_aaf = 4'h0;
		end
		pat.rd_idx = next_pat_idx;
		// Reference entry is held until the first switch instant
		next_gpio = (next_state != dfac_pkg::DFAC_IDLE && pat.count > (AW+1)'(next_pat_idx)) ?
			pat.rd_data : 8'h00;
		samp_on = state != dfac_pkg::DFAC_IDLE && elapsed >= samp_start && elapsed < cte_end;
		next_strobe = samp_on && samp_cnt == '0;
		if (next_strobe) begin
			next_samp_cnt = spacing_cycles(samp_code) - CW'(1);
		end else if (samp_cnt != '0) begin
			next_samp_cnt = samp_cnt - CW'(1);
		end else begin
			next_samp_cnt = '0;
		end
		if (next_state == dfac_pkg::DFAC_IDLE) begin
			next_samp_cnt = '0;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state <= dfac_pkg::DFAC_IDLE;
			elapsed <= '0;
			units <= 6'h00;
			pat_idx <= '0;
			sw_cnt <= '0;
			samp_cnt <= '0;
			antenna_gpio_out <= 8'h00;
			sample_strobe_out <= 1'b0;
			magnitude_phase_format_out <= 1'b0;
			cte_in_extension_out <= 1'b0;
			cte_active_out <= 1'b0;
			low_noise_amp_backoff_out <= 4'h0;
			mixer_backoff_out <= 4'h0;
			antialias_filter_backoff_out <= 4'h0;
		end else begin
			state <= next_state;
			elapsed <= next_elapsed;
			units <= next_units;
			pat_idx <= next_pat_idx;
			sw_cnt <= next_sw_cnt;
			samp_cnt <= next_samp_cnt;
			antenna_gpio_out <= next_gpio;
			sample_strobe_out <= next_strobe;
			magnitude_phase_format_out <= cfg[`DFAC_F_FMT];
			cte_in_extension_out <= cfg[`DFAC_F_PLACE];
			cte_active_out <= next_state != dfac_pkg::DFAC_IDLE;
			low_noise_amp_backoff_out <= next_lna;
			mixer_backoff_out <= next_mix;
			antialias_filter_backoff_out <= next_aaf;
		end
	end

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (reset_in);

	a_place_write: assert property ((ack && wb_we_in && wb_adr_in == `DFAC_ADR_CONFIG && wb_sel_in[0])
		|=> cte_in_extension_out == $past(wb_dat_in[7]))
		else $error("placement output does not follow write");
	a_format_write: assert property ((ack && wb_we_in && wb_adr_in == `DFAC_ADR_CONFIG && wb_sel_in[1])
		|=> magnitude_phase_format_out == $past(wb_dat_in[15]))
		else $error("format output does not follow write");
	a_length_end: assert property ((state != dfac_pkg::DFAC_IDLE && elapsed >= cte_end)
		|=> !cte_active_out && state == dfac_pkg::DFAC_IDLE)
		else $error("procedure outlives its length");
	a_switch_start: assert property ((state == dfac_pkg::DFAC_DELAY && elapsed >= sw_start && elapsed < cte_end)
		|=> state == dfac_pkg::DFAC_REFER)
		else $error("switching did not start at offset");
	a_offset_clamp: assert property (offs[12] |-> sw_start == '0)
		else $error("negative switch offset not clamped");
	a_sample_begin: assert property ((state != dfac_pkg::DFAC_IDLE && elapsed == samp_start && elapsed < cte_end)
		|=> sample_strobe_out)
		else $error("first sample missed its start");
	a_switch_gap: assert property ((state == dfac_pkg::DFAC_SWITCH && sw_tick) |=> !sw_tick [*8])
		else $error("antenna switched too soon");
	a_pattern_wrap: assert property ((sw_tick && pat.count > (AW+1)'(1)
		&& (AW+1)'(pat_idx) + (AW+1)'(1) >= pat.count) |=> pat_idx == AW'(1))
		else $error("pattern walk did not wrap");
	a_clear_empty: assert property ((ack && wb_we_in && wb_adr_in == `DFAC_ADR_CLEAR) |-> pat.count == '0)
		else $error("clear left patterns");
	a_push_append: assert property ((ack && wb_we_in && wb_adr_in == `DFAC_ADR_PUSH && wb_sel_in[0]
		&& $past(pat.count) < (AW+1)'(PATTERN_DEPTH)) |-> pat.count == $past(pat.count) + (AW+1)'(1))
		else $error("pattern write did not append");
	a_gain_order: assert property ((cte_active_out && low_noise_amp_backoff_out < 4'(LNA_MAX_STEPS))
		|-> mixer_backoff_out == 4'h0 && antialias_filter_backoff_out == 4'h0)
		else $error("gain taken out of order");
	a_gain_start: assert property (($rose(cte_active_out) && $past(cfg[27:24]) <= 4'(LNA_MAX_STEPS))
		|-> low_noise_amp_backoff_out == $past(cfg[27:24]))
		else $error("gain back-off not applied at start");
endmodule // dfac_top
